// ==== hdl/twrs_device.sv ====
// register slave end of the two-wire link
//
// Operation
// - idle when both lines high; release data
// - data falls while clock high: start
// - repeated start restarts address byte reception
// - data rises while clock high: stop, idle
// - only master makes start and stop
// - select low: 0x90, select high: 0xBA
// - first byte: address bits 7..1, direction bit 0
// - read address bytes 0x91 or 0xBB
// - eight bits, msb first, then ack bit
// - one data bit per clock period
// - data changes only while clock low
// - transmitter releases; receiver pulls low to ack
// - data high after byte is nack
// - ack address byte only on match
// - write: register address high byte first, acked
// - two data bytes acked, then register written
// - stop or restart ends write
// - random read: address, restart, read byte
// - master acks all read bytes but last
// - current read uses kept register address
// - sequential read continues while master acks
// - sequential write continues until stop
module twrs_device (
  input wire logic clock,
  input wire logic rst,
  twrs_if.device link,
  input wire logic bus_address_select,
  output logic wr_strobe,
  output twrs_pkg::twrs_word_type wr_addr,
  output twrs_pkg::twrs_word_type wr_data,
  output twrs_pkg::twrs_word_type rd_addr,
  input wire twrs_pkg::twrs_word_type rd_data
);
  import twrs_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_WR,
    ST_WR_ACK,
    ST_RD,
    ST_RD_ACK,
    ST_IGNORE
  } twrs_dev_state_type;

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] sel_sync;
  logic scl_prev;
  logic sda_prev;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  twrs_byte_type my_addr;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      sel_sync <= 2'h0;
      scl_prev <= 1'h1;
      sda_prev <= 1'h1;
    end else begin
      scl_sync <= {scl_sync[0], link.clock_pin};
      sda_sync <= {sda_sync[0], link.data_level};
      sel_sync <= {sel_sync[0], bus_address_select};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end

  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl && !scl_prev;
  assign scl_fall = !scl && scl_prev;
  assign start_seen = scl && scl_prev && sda_prev && !sda;
  assign stop_seen = scl && scl_prev && !sda_prev && sda;
  assign my_addr = sel_sync[1] ? TWRS_ADDR_HIGH : TWRS_ADDR_LOW;

  // ---------------------------------------------------------------
  // transfer state
  // ---------------------------------------------------------------
  twrs_dev_state_type state;
  twrs_dev_state_type next_state;
  twrs_byte_type shift;
  twrs_byte_type next_shift;
  logic [3:0] bit_cnt;
  logic [3:0] next_bit_cnt;
  logic [1:0] msg_cnt;
  logic [1:0] next_msg_cnt;
  logic dir_read;
  logic next_dir_read;
  logic sda_low;
  logic next_sda_low;
  twrs_word_type ptr;
  twrs_word_type next_ptr;
  twrs_byte_type data_hi;
  twrs_byte_type next_data_hi;
  twrs_byte_type rd_low;
  twrs_byte_type next_rd_low;
  logic rd_second;
  logic next_rd_second;
  logic master_ack;
  logic next_master_ack;
  logic next_wr_strobe;
  twrs_word_type next_wr_addr;
  twrs_word_type next_wr_data;

  always_comb begin
    next_state = state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_msg_cnt = msg_cnt;
    next_dir_read = dir_read;
    next_sda_low = sda_low;
    next_ptr = ptr;
    next_data_hi = data_hi;
    next_rd_low = rd_low;
    next_rd_second = rd_second;
    next_master_ack = master_ack;
    next_wr_strobe = 1'h0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    if (stop_seen) begin
      next_state = ST_IDLE;
      next_sda_low = 1'h0;
    end else if (start_seen) begin
      next_state = ST_ADDR;
      next_bit_cnt = 4'h0;
      next_sda_low = 1'h0;
    end else begin
      case (state)
        ST_IDLE, ST_IGNORE: begin
          next_sda_low = 1'h0;
        end
        ST_ADDR, ST_WR: begin
          if (scl_rise && bit_cnt != TWRS_ACK_BIT) begin
            next_shift = {shift[6:0], sda};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == TWRS_ACK_BIT) begin
            next_bit_cnt = 4'h0;
            if (state == ST_ADDR) begin
              if (shift[7:1] == my_addr[7:1]) begin
                next_dir_read = shift[0] == TWRS_DIR_READ;
                next_sda_low = 1'h1;
                next_state = ST_ADDR_ACK;
              end else begin
                next_state = ST_IGNORE;
              end
            end else begin
              next_sda_low = 1'h1;
              next_state = ST_WR_ACK;
              next_msg_cnt = msg_cnt + 2'h1;
              case (msg_cnt)
                TWRS_MSG_ADDR_HI: next_ptr[15:8] = shift;
                TWRS_MSG_ADDR_LO: next_ptr[7:0] = shift;
                TWRS_MSG_DATA_HI: next_data_hi = shift;
                default: begin
                  next_wr_strobe = 1'h1;
                  next_wr_addr = ptr;
                  next_wr_data = {data_hi, shift};
                  next_ptr = ptr + 16'h1;
                  next_msg_cnt = TWRS_MSG_DATA_HI;
                end
              endcase
            end
          end
        end
        ST_ADDR_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            next_sda_low = 1'h0;
            if (state == ST_ADDR_ACK && dir_read) begin
              next_state = ST_RD;
              next_shift = rd_data[15:8];
              next_rd_low = rd_data[7:0];
              next_rd_second = 1'h0;
              next_sda_low = !rd_data[15];
            end else begin
              next_state = ST_WR;
              if (state == ST_ADDR_ACK) begin
                next_msg_cnt = TWRS_MSG_ADDR_HI;
              end
            end
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt == TWRS_LAST_BIT) begin
              next_sda_low = 1'h0;
              next_state = ST_RD_ACK;
            end else begin
              next_bit_cnt = bit_cnt + 4'h1;
              next_shift = {shift[6:0], 1'h0};
              next_sda_low = !shift[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            next_master_ack = !sda;
          end else if (scl_fall) begin
            next_bit_cnt = 4'h0;
            if (!master_ack) begin
              next_state = ST_IGNORE;
            end else if (rd_second) begin
              next_state = ST_RD;
              next_shift = rd_data[15:8];
              next_rd_low = rd_data[7:0];
              next_rd_second = 1'h0;
              next_sda_low = !rd_data[15];
            end else begin
              next_state = ST_RD;
              next_shift = rd_low;
              next_rd_second = 1'h1;
              next_sda_low = !rd_low[7];
              next_ptr = ptr + 16'h1;
            end
          end
        end
        default: begin
          next_state = ST_IDLE;
          next_sda_low = 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      msg_cnt <= 2'h0;
      dir_read <= 1'h0;
      sda_low <= 1'h0;
      ptr <= 16'h0000;
      data_hi <= 8'h00;
      rd_low <= 8'h00;
      rd_second <= 1'h0;
      master_ack <= 1'h0;
      wr_strobe <= 1'h0;
      wr_addr <= 16'h0000;
      wr_data <= 16'h0000;
    end else begin
      state <= next_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      msg_cnt <= next_msg_cnt;
      dir_read <= next_dir_read;
      sda_low <= next_sda_low;
      ptr <= next_ptr;
      data_hi <= next_data_hi;
      rd_low <= next_rd_low;
      rd_second <= next_rd_second;
      master_ack <= next_master_ack;
      wr_strobe <= next_wr_strobe;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // open drain: only ever pulls low, never forms start or stop
  assign link.device_data_out = 1'h0;
  assign link.device_data_oe = sda_low;
  assign rd_addr = ptr;
endmodule : twrs_device

// ==== hdl/twrs_if.sv ====
// two-wire link between bus master and register slave
interface twrs_if;
  logic clock_pin;
  logic master_data_out;
  logic master_data_oe;
  logic device_data_out;
  logic device_data_oe;
  logic data_level;

  // open-drain data line with pull-up
  assign data_level = !(master_data_oe && !master_data_out) &&
                      !(device_data_oe && !device_data_out);

  modport master (
    output clock_pin,
    output master_data_out,
    output master_data_oe,
    input data_level
  );

  modport device (
    input clock_pin,
    output device_data_out,
    output device_data_oe,
    input data_level
  );
endinterface : twrs_if

// ==== hdl/twrs_master.sv ====
// bus master end of the two-wire register link
module twrs_master (
  input wire logic clock,
  input wire logic rst,
  twrs_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire twrs_pkg::twrs_op_type cmd_op,
  input wire twrs_pkg::twrs_word_type cmd_addr,
  input wire twrs_pkg::twrs_word_type cmd_data,
  input wire logic cmd_address_select,
  output logic rsp_valid,
  output twrs_pkg::twrs_word_type rsp_data,
  output logic rsp_nack
);
  import twrs_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_NEXT, M_START, M_BITS, M_STOP} twrs_m_state_type;
  typedef enum logic [2:0] {K_START, K_WR, K_RD_ACK, K_RD_NACK, K_STOP} twrs_kind_type;

  // ---------------------------------------------------------------
  // quarter-period divider and data synchroniser
  // ---------------------------------------------------------------
  logic [7:0] div;
  logic [1:0] sda_sync;
  logic tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      div <= 8'h00;
      sda_sync <= 2'h3;
    end else begin
      div <= (div == TWRS_DIV_LAST) ? 8'h00 : div + 8'h01;
      sda_sync <= {sda_sync[0], link.data_level};
    end
  end

  assign tick = div == TWRS_DIV_LAST;

  // ---------------------------------------------------------------
  // command program
  // ---------------------------------------------------------------
  twrs_m_state_type state;
  twrs_m_state_type next_state;
  twrs_op_type op;
  twrs_op_type next_op;
  twrs_word_type addr;
  twrs_word_type next_addr;
  twrs_word_type data;
  twrs_word_type next_data;
  logic sel;
  logic next_sel;
  logic [3:0] step;
  logic [3:0] next_step;
  twrs_kind_type kind;
  twrs_byte_type kind_byte;
  twrs_byte_type dev;

  always_comb begin
    dev = sel ? TWRS_ADDR_HIGH : TWRS_ADDR_LOW;
    kind = K_STOP;
    kind_byte = {dev[7:1], TWRS_DIR_WRITE};
    case (op)
      TWRS_OP_WRITE: begin
        case (step)
          4'h0: kind = K_START;
          4'h1: kind = K_WR;
          4'h2: begin
            kind = K_WR;
            kind_byte = addr[15:8];
          end
          4'h3: begin
            kind = K_WR;
            kind_byte = addr[7:0];
          end
          4'h4: begin
            kind = K_WR;
            kind_byte = data[15:8];
          end
          4'h5: begin
            kind = K_WR;
            kind_byte = data[7:0];
          end
          default: kind = K_STOP;
        endcase
      end
      TWRS_OP_READ_RANDOM: begin
        case (step)
          4'h0: kind = K_START;
          4'h1: kind = K_WR;
          4'h2: begin
            kind = K_WR;
            kind_byte = addr[15:8];
          end
          4'h3: begin
            kind = K_WR;
            kind_byte = addr[7:0];
          end
          4'h4: kind = K_START;
          4'h5: begin
            kind = K_WR;
            kind_byte = {dev[7:1], TWRS_DIR_READ};
          end
          4'h6: kind = K_RD_ACK;
          4'h7: kind = K_RD_NACK;
          default: kind = K_STOP;
        endcase
      end
      default: begin
        case (step)
          4'h0: kind = K_START;
          4'h1: begin
            kind = K_WR;
            kind_byte = {dev[7:1], TWRS_DIR_READ};
          end
          4'h2: kind = K_RD_ACK;
          4'h3: kind = K_RD_NACK;
          default: kind = K_STOP;
        endcase
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bit engine
  // ---------------------------------------------------------------
  logic [1:0] q;
  logic [1:0] next_q;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  twrs_byte_type tx;
  twrs_byte_type next_tx;
  twrs_byte_type rx;
  twrs_byte_type next_rx;
  logic scl_out;
  logic next_scl_out;
  logic sda_low;
  logic next_sda_low;
  logic nack;
  logic next_nack;
  logic next_rsp_valid;
  twrs_word_type next_rsp_data;

  always_comb begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_data = data;
    next_sel = sel;
    next_step = step;
    next_q = q;
    next_bit_idx = bit_idx;
    next_tx = tx;
    next_rx = rx;
    next_scl_out = scl_out;
    next_sda_low = sda_low;
    next_nack = nack;
    next_rsp_valid = 1'h0;
    next_rsp_data = rsp_data;
    case (state)
      M_IDLE: begin
        if (cmd_valid) begin
          next_op = cmd_op;
          next_addr = cmd_addr;
          next_data = cmd_data;
          next_sel = cmd_address_select;
          next_step = 4'h0;
          next_nack = 1'h0;
          next_state = M_NEXT;
        end
      end
      M_NEXT: begin
        next_q = 2'h0;
        next_bit_idx = 4'h0;
        next_tx = kind_byte;
        case (kind)
          K_START: next_state = M_START;
          K_STOP: next_state = M_STOP;
          default: next_state = M_BITS;
        endcase
      end
      M_START: begin
        if (tick) begin
          next_q = q + 2'h1;
          case (q)
            2'h0: next_sda_low = 1'h0;
            2'h1: next_scl_out = 1'h1;
            2'h2: next_sda_low = 1'h1;
            default: begin
              next_scl_out = 1'h0;
              next_step = step + 4'h1;
              next_state = M_NEXT;
            end
          endcase
        end
      end
      M_STOP: begin
        if (tick) begin
          next_q = q + 2'h1;
          case (q)
            2'h0: next_sda_low = 1'h1;
            2'h1: next_scl_out = 1'h1;
            2'h2: next_sda_low = 1'h0;
            default: begin
              next_rsp_valid = 1'h1;
              next_state = M_IDLE;
            end
          endcase
        end
      end
      M_BITS: begin
        if (tick) begin
          next_q = q + 2'h1;
          case (q)
            2'h0: begin
              if (bit_idx == TWRS_ACK_BIT) begin
                next_sda_low = kind == K_RD_ACK;
              end else begin
                next_sda_low = kind == K_WR && !tx[7];
              end
            end
            2'h1: next_scl_out = 1'h1;
            2'h2: begin
              if (bit_idx != TWRS_ACK_BIT) begin
                next_rx = {rx[6:0], sda_sync[1]};
              end else if (kind == K_WR && sda_sync[1]) begin
                next_nack = 1'h1;
              end
            end
            default: begin
              next_scl_out = 1'h0;
              if (bit_idx != TWRS_ACK_BIT) begin
                next_bit_idx = bit_idx + 4'h1;
                next_tx = {tx[6:0], 1'h0};
              end else begin
                if (kind != K_WR) begin
                  next_rsp_data = {rsp_data[7:0], rx};
                end
                next_step = step + 4'h1;
                next_state = nack ? M_STOP : M_NEXT;
              end
            end
          endcase
        end
      end
      default: next_state = M_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= M_IDLE;
      op <= TWRS_OP_WRITE;
      addr <= 16'h0000;
      data <= 16'h0000;
      sel <= 1'h0;
      step <= 4'h0;
      q <= 2'h0;
      bit_idx <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      scl_out <= 1'h1;
      sda_low <= 1'h0;
      nack <= 1'h0;
      rsp_valid <= 1'h0;
      rsp_data <= 16'h0000;
    end else begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      data <= next_data;
      sel <= next_sel;
      step <= next_step;
      q <= next_q;
      bit_idx <= next_bit_idx;
      tx <= next_tx;
      rx <= next_rx;
      scl_out <= next_scl_out;
      sda_low <= next_sda_low;
      nack <= next_nack;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  assign cmd_ready = state == M_IDLE;
  assign rsp_nack = nack;
  assign link.clock_pin = scl_out;
  assign link.master_data_out = 1'h0;
  assign link.master_data_oe = sda_low;
endmodule : twrs_master

// ==== hdl/twrs_pkg.sv ====
// constants and types shared by both ends of the two-wire register link
package twrs_pkg;
  typedef logic [15:0] twrs_word_type;
  typedef logic [7:0] twrs_byte_type;
  typedef enum logic [1:0] {
    TWRS_OP_WRITE,
    TWRS_OP_READ_RANDOM,
    TWRS_OP_READ_CURRENT
  } twrs_op_type;

  // ---------------------------------------------------------------
  // addressing
  // ---------------------------------------------------------------
  localparam twrs_byte_type TWRS_ADDR_LOW = 8'h90;
  localparam twrs_byte_type TWRS_ADDR_HIGH = 8'hBA;
  localparam logic TWRS_DIR_WRITE = 1'h0;
  localparam logic TWRS_DIR_READ = 1'h1;

  // ---------------------------------------------------------------
  // framing
  // ---------------------------------------------------------------
  localparam logic [3:0] TWRS_LAST_BIT = 4'h7;
  localparam logic [3:0] TWRS_ACK_BIT = 4'h8;
  localparam logic [1:0] TWRS_MSG_ADDR_HI = 2'h0;
  localparam logic [1:0] TWRS_MSG_ADDR_LO = 2'h1;
  localparam logic [1:0] TWRS_MSG_DATA_HI = 2'h2;
  localparam logic [1:0] TWRS_MSG_DATA_LO = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int TWRS_CLOCK_PS = 4000;
  localparam int TWRS_LINK_PERIOD_NS = 2500;
  localparam int TWRS_QUARTER_CYC =
    (TWRS_LINK_PERIOD_NS * 1000 / 4 + TWRS_CLOCK_PS - 1) / TWRS_CLOCK_PS;
  localparam logic [7:0] TWRS_DIV_LAST = 8'(TWRS_QUARTER_CYC - 1);
endpackage : twrs_pkg

// ==== verif/test_two_wire_register_slave.sv ====
// self-checking bench for both ends of the two-wire register link
module test_two_wire_register_slave;
  timeunit 1ns;
  timeprecision 1ps;
  import twrs_pkg::*;

`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin mismatches++; $display("Error at %0t: got %h expected %h", $time, g, e); end end

  logic clock, rst, sel, cmd_valid, cmd_ready, cmd_sel, rsp_valid, rsp_nack, wr_strobe;
  twrs_op_type cmd_op;
  twrs_word_type cmd_addr, cmd_data, rsp_data, wr_addr, wr_data, rd_addr, rd_data;
  twrs_word_type exp_wa, exp_wd, ptr, a, d;
  twrs_word_type regs[twrs_word_type];
  twrs_word_type mem[twrs_word_type];
  logic [15:0] lf;
  int mismatches, checks_done, strobes;

  twrs_if link();
  twrs_master u_twrs_master(.clock(clock), .rst(rst), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_address_select(cmd_sel), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_nack(rsp_nack));
  twrs_device u_twrs_device(.clock(clock), .rst(rst), .link(link), .bus_address_select(sel),
    .wr_strobe(wr_strobe), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
    .rd_data(rd_data));
  twrs_link_asserts u_twrs_link_asserts(.clock(clock), .rst(rst),
    .clock_pin(link.clock_pin), .master_data_oe(link.master_data_oe),
    .device_data_oe(link.device_data_oe), .data_level(link.data_level),
    .bus_address_select(sel));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr_next

  function automatic twrs_word_type mdl(input twrs_word_type x);
    return mem.exists(x) ? mem[x] : x ^ 16'h5A5A;
  endfunction : mdl

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // register file behind the slave, refreshed off the sampling edge
  always @(negedge clock) begin
    if (wr_strobe === 1'b1) begin
      strobes++;
      regs[wr_addr] = wr_data;
      `CHK(wr_addr, exp_wa)
      `CHK(wr_data, exp_wd)
    end
    rd_data <= regs.exists(rd_addr) ? regs[rd_addr] : rd_addr ^ 16'h5A5A;
  end

  task automatic run(input twrs_op_type op, input twrs_word_type ad, dt, input logic s);
    int n, st;
    logic hit;
    twrs_word_type e;
    st = strobes;
    hit = (s === sel);
    if (op == TWRS_OP_READ_RANDOM) begin
      ptr = ad;
    end
    e = mdl(ptr);
    exp_wa = ad;
    exp_wd = dt;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad;
    cmd_data = dt;
    cmd_sel = s;
    @(negedge clock);
    cmd_valid = 1'b0;
    for (n = 0; n < 60000 && rsp_valid !== 1'b1; n++) begin
      @(negedge clock);
    end
    if (n == 60000) begin
      mismatches++;
      give_verdict();
    end else begin
      `CHK(cmd_ready, 1'b1)
      if (op == TWRS_OP_WRITE) begin
        `CHK(rsp_nack, !hit)
        `CHK(strobes - st, hit ? 1 : 0)
        if (hit) begin
          mem[ad] = dt;
          ptr = ad + 16'h0001;
        end
      end else begin
        `CHK(rsp_nack, 1'b0)
        `CHK(rsp_data, e)
        ptr = ptr + 16'h0001;
      end
      `CHK(rd_addr, ptr)
      @(negedge clock);
    end
  endtask : run

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    lf = lfsr_next(16'h40BB);
    {rst, cmd_valid, cmd_sel} = {1'b1, 1'b0, 1'b0};
    {cmd_op, cmd_addr, cmd_data} = {TWRS_OP_WRITE, 16'h0000, 16'h0000};
    sel = lf[0];
    ptr = 16'h0000;
    repeat (20) @(negedge clock);
    rst = 1'b0;
    lf = lfsr_next(lf);
    a = lf;
    lf = lfsr_next(lf);
    d = lf;
    run(TWRS_OP_WRITE, a ^ 16'h00FF, d, !sel);
    run(TWRS_OP_WRITE, a, d, sel);
    run(TWRS_OP_READ_RANDOM, a, 16'h0000, sel);
    run(TWRS_OP_READ_CURRENT, 16'h0000, 16'h0000, sel);
    give_verdict();
  end
endmodule : test_two_wire_register_slave

// ==== verif/twrs_link_asserts.sv ====
// concurrent checks on the two-wire link between master and slave
module twrs_link_asserts
  import twrs_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_pin,
  input wire logic master_data_oe,
  input wire logic device_data_oe,
  input wire logic data_level,
  input wire logic bus_address_select
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------
  // frame tracking
  // ---------------------------------------------------------------
  logic last_clk;
  logic last_data;
  logic [3:0] cnt;
  logic [7:0] sh;
  logic first, hit, rd, nacked, miss, idle;
  logic start_c, stop_c, rise, fall, ack_rise, hit_now;
  twrs_byte_type own;

  assign own = bus_address_select ? TWRS_ADDR_HIGH : TWRS_ADDR_LOW;
  assign start_c = clock_pin && last_clk && last_data && !data_level;
  assign stop_c = clock_pin && last_clk && !last_data && data_level;
  assign rise = clock_pin && !last_clk;
  assign fall = !clock_pin && last_clk;
  assign ack_rise = rise && (cnt == 4'h9);
  assign hit_now = (sh[7:1] == own[7:1]);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      last_clk <= 1'b1;
      last_data <= 1'b1;
      cnt <= 4'h0;
      sh <= 8'h00;
      {first, hit, rd, nacked, miss} <= 5'h00;
      idle <= 1'b1;
    end else begin
      last_clk <= clock_pin;
      last_data <= data_level;
      if (start_c) begin
        cnt <= 4'h0;
        {first, hit, rd, nacked, miss, idle} <= 6'h20;
      end else if (stop_c) begin
        {first, hit, rd, nacked, miss, idle} <= 6'h01;
      end else begin
        if (fall) begin
          cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
        end
        if (rise) begin
          sh <= {sh[6:0], data_level};
        end
        if (ack_rise && first) begin
          first <= 1'b0;
          hit <= hit_now;
          rd <= sh[0];
          miss <= !hit_now;
        end
        if (ack_rise && !first && hit && rd && data_level) begin
          nacked <= 1'b1;
        end
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_addr_ack_match: assert property (ack_rise && first |-> !data_level == hit_now)
    else $error("address acknowledge does not follow the match");
  a_write_byte_ack: assert property (ack_rise && !first && hit && !rd |-> !data_level)
    else $error("written byte not acknowledged");
  a_read_slot_free: assert property (ack_rise && !first && hit && rd |-> !device_data_oe)
    else $error("slave drives the acknowledge slot of a read byte");
  a_nack_quiet: assert property (nacked |-> !device_data_oe)
    else $error("slave drives data after a no-acknowledge");
  a_miss_quiet: assert property (miss |-> !device_data_oe)
    else $error("unaddressed slave drives data");
  a_idle_released: assert property (idle |-> !device_data_oe)
    else $error("slave drives data on an idle bus");
  a_start_by_master: assert property (start_c |-> !device_data_oe)
    else $error("slave takes part in a start condition");
  a_stable_clock_high: assert property (clock_pin && last_clk |-> $stable(device_data_oe))
    else $error("slave changes data while the clock is high");
  a_clock_low_span: assert property ($fell(clock_pin) |-> !clock_pin [*8])
    else $error("clock low phase too short");
  a_clock_high_span: assert property ($rose(clock_pin) |-> clock_pin [*8])
    else $error("clock high phase too short");

  c_start: cover property (start_c);
  c_read_hit: cover property (ack_rise && first && hit_now && sh[0]);
  c_nack: cover property ($rose(nacked));
  c_miss: cover property ($rose(miss));
endmodule : twrs_link_asserts
